// [spc_pkg.sv]
// shared constants and types for the serial port error and power control block
package spc_pkg;

  // ---------------------------------------------------------------
  // data path geometry
  // ---------------------------------------------------------------
  localparam int SPC_BYTE_W = 8;
  localparam int SPC_CNT_W = 3;
  localparam logic [2:0] SPC_LAST_BIT = 3'h7;
  localparam logic [3:0] SPC_LAST_EDGE = 4'hF;

  // ---------------------------------------------------------------
  // master clock divider and pin synchronisers
  // ---------------------------------------------------------------
  localparam int SPC_HALF_DIV_DEF = 5;
  // a launched miso bit is seen four edges later, so capture needs the fifth
  localparam int SPC_HALF_DIV_MIN = 5;
  localparam int SPC_SYNC_N = 3;
  localparam logic [SPC_SYNC_N-1:0] SPC_SYNC_RST = 3'h1;

  // ---------------------------------------------------------------
  // reset values of control and status bits
  // ---------------------------------------------------------------
  localparam logic SPC_CTL_RST = 1'b0;
  localparam logic SPC_FLAG_RST = 1'b0;
  localparam logic SPC_SEL_LEVEL_RST = 1'b0;
  localparam logic [SPC_BYTE_W-1:0] SPC_DATA_RST = 8'h00;

  // master engine states, one-hot
  typedef enum logic [1:0]
  {
    SPC_MST_IDLE = 2'b01,
    SPC_MST_RUN = 2'b10
  } spc_mst_e;

endpackage

// [spc_slave_shift.sv]
// slave shift engine clocked by the serial clock of the far master
`timescale 1ns/10ps
module spc_slave_shift
  import spc_pkg::*;
(
  input wire logic sck_link,
  input wire logic rst_b,
  input wire logic frame_act,
  input wire logic cap_invert,
  input wire logic capture_edge_select,
  input wire logic [SPC_BYTE_W-1:0] tx_byte,
  input wire logic mosi_in,
  output logic miso_out,
  output logic [SPC_BYTE_W-1:0] rx_byte_q,
  output logic done_tgl_q
);

  logic sck_cap;
  logic frame_rst_b;
  logic [SPC_CNT_W-1:0] cap_cnt_q;
  logic [SPC_CNT_W-1:0] launch_cnt_q;
  logic [SPC_BYTE_W-2:0] in_sh_q;
  logic [SPC_CNT_W-1:0] out_idx;

  // ---------------------------------------------------------------
  // edge selection
  // ---------------------------------------------------------------
  // capture edge becomes the rising edge; config must stay static while enabled
  assign sck_cap = sck_link ^ cap_invert;
  // frame ends by its own select, so a stopped clock never strands a byte
  assign frame_rst_b = frame_act & rst_b;

  // ---------------------------------------------------------------
  // receive side
  // ---------------------------------------------------------------
  // msb arrives first, shifts toward the top
  always_ff @(posedge sck_cap or negedge frame_rst_b)
    if (!frame_rst_b)
    begin
      cap_cnt_q <= '0;
      in_sh_q <= '0;
    end
    else
    begin
      in_sh_q <= {in_sh_q[SPC_BYTE_W-3:0], mosi_in};
      cap_cnt_q <= cap_cnt_q + 1'b1;
    end

  // completed byte and its toggle survive the end of the frame
  always_ff @(posedge sck_cap or negedge rst_b)
    if (!rst_b)
    begin
      rx_byte_q <= SPC_DATA_RST;
      done_tgl_q <= 1'b0;
    end
    else if (frame_rst_b && cap_cnt_q == SPC_LAST_BIT)
    begin
      rx_byte_q <= {in_sh_q, mosi_in};
      done_tgl_q <= ~done_tgl_q;
    end

  // ---------------------------------------------------------------
  // transmit side
  // ---------------------------------------------------------------
  // launch edges count bits already presented
  always_ff @(negedge sck_cap or negedge frame_rst_b)
    if (!frame_rst_b)
      launch_cnt_q <= '0;
    else
      launch_cnt_q <= launch_cnt_q + 1'b1;

  // with late capture the first launch edge presents the msb
  assign out_idx = launch_cnt_q - {2'b00, capture_edge_select};
  // pin bit picked straight from the held byte, msb first
  assign miso_out = tx_byte[SPC_LAST_BIT - out_idx];

endmodule

// [spc_port.sv]
// serial port core: master engine, error flags, interrupt and low power control
// How it works
// - polarity and phase bits choose among four capture edge timings
// - master seeing select low sets mode fault and may interrupt
// - mode fault clears port enable and master select
// - mode fault clears by status read then control write
// - while mode fault is set, enable and master can be set only by the clearing control write
// - slave never sets mode fault; stale flag may remain
// - byte done while done flag set raises overrun and interrupt
// - overrun keeps earlier byte, drops later ones, clears on status read
// - data write during a master transfer, or while an early capture slave is selected, is dropped and sets collision flag
// - collision flag never requests an interrupt
// - received bytes go to a cpu side buffer
// - slave with no new write shifts last received byte back
// - wait mode keeps running; interrupt events wake the device
// - halt freezes the master engine and fault detection until a wake interrupt; the slave keeps shifting
// - only slave transfer done ends halt; repeats raise overrun
// - halt wake needs internal select low at halt entry
// - done, fault and overrun share one gated interrupt request
// - done flag clears by status access then data access
// - soft select mode replaces the select pin with a level bit
// - bytes travel msb first on the master's clock
`timescale 1ns/10ps
module spc_port
  import spc_pkg::*;
#(
  parameter int MST_HALF_DIV = SPC_HALF_DIV_DEF
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sck_link,
  input wire logic ctl_wr,
  input wire logic ctl_irq_enable,
  input wire logic ctl_port_enable,
  input wire logic ctl_master_select,
  input wire logic ctl_clock_idle_level,
  input wire logic ctl_capture_edge_select,
  input wire logic csr_wr,
  input wire logic csr_rd,
  input wire logic csr_soft_select_mode,
  input wire logic csr_soft_select_level,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [SPC_BYTE_W-1:0] data_wdata,
  output logic [SPC_BYTE_W-1:0] data_rdata,
  output logic transfer_done_flag,
  output logic write_collision_flag,
  output logic overrun_flag,
  output logic mode_fault_flag,
  output logic port_enable,
  output logic master_select,
  input wire logic cpu_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  output logic irq_req,
  output logic wake_req,
  input wire logic ss_pin_b,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe
);

  logic irq_enable_q;
  logic pe_q;
  logic ms_q;
  logic clock_idle_level_q;
  logic capture_edge_select_q;
  logic ssm_q;
  logic ssl_q;
  logic tdf_q;
  logic tdf_arm_q;
  logic ovr_q;
  logic write_collision_flag_q;
  logic wc_arm_q;
  logic mf_q;
  logic mf_arm_q;
  logic halt_d_q;
  logic halt_sel_q;
  logic done_seen_q;
  logic mst_done_q;
  logic sck_tgl_q;
  logic [SPC_BYTE_W-1:0] tx_byte_q;
  logic [SPC_BYTE_W-1:0] rx_buf_q;
  logic [SPC_BYTE_W-1:0] tx_sh_q;
  logic [SPC_BYTE_W-1:0] rx_sh_q;
  logic [3:0] edge_q;
  logic [7:0] div_q;
  spc_mst_e st_q;
  logic [SPC_SYNC_N-1:0] sync_raw;
  logic [SPC_SYNC_N-1:0] sync_lvl;
  logic ss_raw;
  logic ss_int;
  logic miso_s;
  logic slv_done;
  logic slv_miso;
  logic slv_done_tgl;
  logic [SPC_BYTE_W-1:0] slv_rx;
  logic complete;
  logic [SPC_BYTE_W-1:0] done_byte;
  logic busy;
  logic wr_blocked;
  logic tdf_clr;
  logic fault_set;
  logic mf_ok;
  logic tick;
  logic cap_edge;

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  // pin synchroniser latency needs at least this many cycles per half clock
  generate
    if (MST_HALF_DIV < SPC_HALF_DIV_MIN || MST_HALF_DIV > 255)
    begin : g_bad_div
      $error("MST_HALF_DIV out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  assign sync_raw = {slv_done_tgl, miso_in, ss_pin_b};

  // a change counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < SPC_SYNC_N; gi++)
    begin : g_sync
      logic [2:0] stg_q;
      logic lvl_q;
      always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
        begin
          stg_q <= {3{SPC_SYNC_RST[gi]}};
          lvl_q <= SPC_SYNC_RST[gi];
        end
        else
        begin
          stg_q <= {stg_q[1:0], sync_raw[gi]};
          if (stg_q[1] == stg_q[2])
            lvl_q <= stg_q[2];
        end
      assign sync_lvl[gi] = lvl_q;
    end
  endgenerate

  assign miso_s = sync_lvl[1];
  // soft select mode frees the pin and uses the level bit
  assign ss_int = ssm_q ? ssl_q : sync_lvl[0];
  // unsynchronised copy frames the link side shifter and gates miso_oe
  assign ss_raw = ssm_q ? ssl_q : ss_pin_b;

  // ---------------------------------------------------------------
  // slave engine on the link clock
  // ---------------------------------------------------------------
  spc_slave_shift u_slave
  (
    .sck_link(sck_link),
    .rst_b(rst_b),
    .frame_act(pe_q & ~ms_q & ~ss_raw),
    .cap_invert(clock_idle_level_q ^ capture_edge_select_q),
    .capture_edge_select(capture_edge_select_q),
    .tx_byte(tx_byte_q),
    .mosi_in(mosi_in),
    .miso_out(slv_miso),
    .rx_byte_q(slv_rx),
    .done_tgl_q(slv_done_tgl)
  );

  // slave byte event, taken once per toggle; slave byte is stable by then
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      done_seen_q <= 1'b0;
    else
      done_seen_q <= sync_lvl[2];

  assign slv_done = sync_lvl[2] ^ done_seen_q;
  assign complete = slv_done | mst_done_q;
  assign done_byte = mst_done_q ? rx_sh_q : slv_rx;

  // ---------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------
  // master with select low faults; a slave never does, halt freezes it
  assign fault_set = ms_q & ~ss_int & ~halt_mode;
  // setting enable or master is refused unless the flag is gone or armed
  assign mf_ok = ~mf_q | mf_arm_q;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      irq_enable_q <= SPC_CTL_RST;
      pe_q <= SPC_CTL_RST;
      ms_q <= SPC_CTL_RST;
      clock_idle_level_q <= SPC_CTL_RST;
      capture_edge_select_q <= SPC_CTL_RST;
    end
    else if (fault_set)
    begin
      pe_q <= 1'b0;
      ms_q <= 1'b0;
    end
    else if (ctl_wr)
    begin
      irq_enable_q <= ctl_irq_enable;
      pe_q <= ctl_port_enable & mf_ok;
      ms_q <= ctl_master_select & mf_ok;
      clock_idle_level_q <= ctl_clock_idle_level;
      capture_edge_select_q <= ctl_capture_edge_select;
    end

  // select management bits
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      ssm_q <= SPC_CTL_RST;
      ssl_q <= SPC_SEL_LEVEL_RST;
    end
    else if (csr_wr)
    begin
      ssm_q <= csr_soft_select_mode;
      ssl_q <= csr_soft_select_level;
    end

  // ---------------------------------------------------------------
  // mode fault flag
  // ---------------------------------------------------------------
  // set wins over the clearing control write
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      mf_q <= SPC_FLAG_RST;
      mf_arm_q <= 1'b0;
    end
    else if (fault_set)
    begin
      mf_q <= 1'b1;
      mf_arm_q <= mf_arm_q & ~ctl_wr;
    end
    else if (mf_arm_q && ctl_wr)
    begin
      mf_q <= 1'b0;
      mf_arm_q <= 1'b0;
    end
    else if (csr_rd && mf_q)
      mf_arm_q <= 1'b1;

  // ---------------------------------------------------------------
  // transfer done and overrun
  // ---------------------------------------------------------------
  assign tdf_clr = tdf_arm_q & (data_rd | data_wr);

  // a completion landing on the clearing access keeps the flag set
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      tdf_q <= SPC_FLAG_RST;
      tdf_arm_q <= 1'b0;
    end
    else if (complete)
    begin
      tdf_q <= 1'b1;
      tdf_arm_q <= tdf_arm_q & ~tdf_clr;
    end
    else if (tdf_clr)
    begin
      tdf_q <= 1'b0;
      tdf_arm_q <= 1'b0;
    end
    else if ((csr_rd || csr_wr) && tdf_q)
      tdf_arm_q <= 1'b1;

  // overrun: set wins over the status read that clears it
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      ovr_q <= SPC_FLAG_RST;
    else if (complete && tdf_q && !tdf_clr)
      ovr_q <= 1'b1;
    else if (csr_rd)
      ovr_q <= 1'b0;

  // cpu reads only this buffer, never the shifter
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      rx_buf_q <= SPC_DATA_RST;
    else if (complete && !(tdf_q && !tdf_clr))
      rx_buf_q <= done_byte;

  assign data_rdata = rx_buf_q;

  // ---------------------------------------------------------------
  // data writes and write collision
  // ---------------------------------------------------------------
  // slave with early capture is mid byte whenever selected
  assign busy = (st_q == SPC_MST_RUN) | (pe_q & ~ms_q & ~ss_int & ~capture_edge_select_q);
  // writes wait for a status read or write while done is pending
  assign wr_blocked = tdf_q & ~tdf_arm_q;

  // transmit byte; an idle slave echoes what it last took in
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      tx_byte_q <= SPC_DATA_RST;
    else if (data_wr && !busy && !wr_blocked)
      tx_byte_q <= data_wdata;
    else if (slv_done && !ms_q)
      tx_byte_q <= slv_rx;

  // collision is status only; it feeds no interrupt
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      write_collision_flag_q <= SPC_FLAG_RST;
      wc_arm_q <= 1'b0;
    end
    else if (data_wr && busy)
    begin
      write_collision_flag_q <= 1'b1;
      wc_arm_q <= wc_arm_q & ~data_rd;
    end
    else if (wc_arm_q && data_rd)
    begin
      write_collision_flag_q <= 1'b0;
      wc_arm_q <= 1'b0;
    end
    else if (csr_rd && write_collision_flag_q)
      wc_arm_q <= 1'b1;

  // ---------------------------------------------------------------
  // master engine
  // ---------------------------------------------------------------
  assign tick = div_q == 8'(MST_HALF_DIV - 1);
  // even edges capture with early phase, odd ones with late phase
  assign cap_edge = edge_q[0] == capture_edge_select_q;

  // one byte is sixteen serial clock edges; halt freezes it
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      st_q <= SPC_MST_IDLE;
      div_q <= '0;
      edge_q <= '0;
      sck_tgl_q <= 1'b0;
      tx_sh_q <= SPC_DATA_RST;
      rx_sh_q <= SPC_DATA_RST;
      mst_done_q <= 1'b0;
    end
    else
    begin
      mst_done_q <= 1'b0;
      case (st_q)
        SPC_MST_IDLE:
        begin
          div_q <= '0;
          edge_q <= '0;
          sck_tgl_q <= 1'b0;
          if (data_wr && !wr_blocked && ms_q && pe_q && !busy)
          begin
            tx_sh_q <= data_wdata;
            st_q <= SPC_MST_RUN;
          end
        end
        SPC_MST_RUN:
        begin
          if (!pe_q || !ms_q)
            st_q <= SPC_MST_IDLE; // fault aborts the byte
          else if (!halt_mode)
          begin
            div_q <= tick ? '0 : div_q + 1'b1;
            if (tick)
            begin
              sck_tgl_q <= ~sck_tgl_q;
              edge_q <= edge_q + 1'b1;
              if (cap_edge)
                rx_sh_q <= {rx_sh_q[SPC_BYTE_W-2:0], miso_s};
              else if (edge_q != 4'h0)
                tx_sh_q <= {tx_sh_q[SPC_BYTE_W-2:0], 1'b0};
              if (edge_q == SPC_LAST_EDGE)
              begin
                mst_done_q <= 1'b1;
                st_q <= SPC_MST_IDLE;
              end
            end
          end
        end
        default:
          st_q <= SPC_MST_IDLE;
      endcase
    end

  // ---------------------------------------------------------------
  // low power
  // ---------------------------------------------------------------
  // select level is caught as halt begins
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      halt_d_q <= 1'b0;
      halt_sel_q <= 1'b0;
    end
    else
    begin
      halt_d_q <= halt_mode;
      if (halt_mode && !halt_d_q)
        halt_sel_q <= ~ss_int;
    end

  // shared request; only slave done may end halt
  assign irq_req = irq_enable_q & ~cpu_irq_mask & (tdf_q | mf_q | ovr_q);
  assign wake_req = (wait_mode & irq_req)
    | (halt_mode & halt_sel_q & ~ms_q & irq_enable_q & tdf_q);

  // ---------------------------------------------------------------
  // pins and status
  // ---------------------------------------------------------------
  // clock idles at the polarity level; disabled port drives nothing
  assign sck_out = clock_idle_level_q ^ sck_tgl_q;
  assign sck_oe = pe_q & ms_q;
  assign mosi_out = tx_sh_q[SPC_BYTE_W-1];
  assign mosi_oe = pe_q & ms_q;
  assign miso_out = slv_miso;
  assign miso_oe = pe_q & ~ms_q & ~ss_raw;

  assign transfer_done_flag = tdf_q;
  assign write_collision_flag = write_collision_flag_q;
  assign overrun_flag = ovr_q;
  assign mode_fault_flag = mf_q;
  assign port_enable = pe_q;
  assign master_select = ms_q;

endmodule

// [spc_port_assertions.sv]
// checker of flag, enable and request relations of the serial port core
`timescale 1ns/10ps
module spc_port_chk
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ctl_wr,
  input wire logic csr_rd,
  input wire logic data_wr,
  input wire logic cpu_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic transfer_done_flag,
  input wire logic write_collision_flag,
  input wire logic overrun_flag,
  input wire logic mode_fault_flag,
  input wire logic port_enable,
  input wire logic master_select,
  input wire logic irq_req,
  input wire logic wake_req
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ----
  // fault clear arming
  // ----
  logic fault_arm_q;
  // a status read arms the clear; any control write disarms it
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      fault_arm_q <= 1'b0;
    else
      fault_arm_q <= !ctl_wr && mode_fault_flag && (csr_rd || fault_arm_q);
  end
  // ----
  // properties
  // ----
  a_irq_source: assert property (
    irq_req |-> !cpu_irq_mask && (transfer_done_flag || mode_fault_flag || overrun_flag))
    else $error("request without enabled source");
  a_wake_cause: assert property (
    wake_req |-> (wait_mode && irq_req) || (halt_mode && transfer_done_flag && !master_select))
    else $error("wake without allowed cause");
  a_fault_drops_enable: assert property (
    $rose(mode_fault_flag) |-> !port_enable && !master_select)
    else $error("fault left port enabled");
  a_fault_blocks_set: assert property (
    mode_fault_flag && ctl_wr && !fault_arm_q |=> mode_fault_flag && !port_enable && !master_select)
    else $error("enable set during fault");
  a_fault_clear_seq: assert property (
    mode_fault_flag && ctl_wr && fault_arm_q |=> !mode_fault_flag)
    else $error("fault not cleared");
  a_slave_no_fault: assert property (
    !master_select && !mode_fault_flag && !ctl_wr |=> !mode_fault_flag)
    else $error("fault set in slave");
  a_ovr_cause: assert property (
    $rose(overrun_flag) |-> $past(transfer_done_flag))
    else $error("overrun without pending done");
  a_ovr_clear: assert property (
    overrun_flag && csr_rd |=> !overrun_flag)
    else $error("overrun kept after status read");
  a_write_collision_flag_cause: assert property (
    $rose(write_collision_flag) |-> $past(data_wr))
    else $error("collision without data write");
endmodule

bind spc_port spc_port_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .ctl_wr(ctl_wr), .csr_rd(csr_rd),
  .data_wr(data_wr), .cpu_irq_mask(cpu_irq_mask), .wait_mode(wait_mode), .halt_mode(halt_mode),
  .transfer_done_flag(transfer_done_flag), .write_collision_flag(write_collision_flag),
  .overrun_flag(overrun_flag), .mode_fault_flag(mode_fault_flag), .port_enable(port_enable),
  .master_select(master_select), .irq_req(irq_req), .wake_req(wake_req));

// [spc_far_end.sv]
// behavioural far end: serial master for slave tests, serial slave for master tests
`timescale 1ns/10ps
module spc_far_end
(
  input wire logic clk_pol,
  input wire logic clk_pha,
  input wire logic sck_m,
  input wire logic mosi_m,
  input wire logic miso_s,
  output logic sck_link,
  output logic mosi_f,
  output logic miso_f
);
  logic [7:0] sreg = 8'h00;
  logic [7:0] rx = 8'h00;
  int cnt = 99;
  initial sck_link = 1'b0;
  initial mosi_f = 1'b1;
  // slave role: edge count picks capture edges, msb first
  always @(sck_m)
  begin
    cnt = cnt + 1;
    if (cnt <= 16 && cnt[0] != clk_pha)
      rx = {rx[6:0], mosi_m};
  end
  // outside a frame the line shows the inverse of its last bit, not a held value
  assign miso_f = (cnt < 16) ? sreg[7 - (cnt - int'(clk_pha)) / 2] : ~sreg[0];
  task load(input logic [7:0] b);
    sreg = b;
    cnt = 0;
  endtask
  // master role at 64 ns per bit; clock rests at the polarity level between frames
  task send(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      if (!clk_pha) mosi_f = b[i];
      #32 sck_link = !clk_pol;
      if (clk_pha) mosi_f = b[i];
      else r[i] = miso_s;
      #32 sck_link = clk_pol;
      if (clk_pha) r[i] = miso_s;
    end
    #32 mosi_f = !mosi_f;
  endtask
endmodule

// [spc_port_tb_top.sv]
// testbench of the serial port core with a behavioural far end
`timescale 1ns/10ps
module spc_port_tb_top;
  localparam logic [4:0] CTL = 5'h10, CSW = 5'h08, CSR = 5'h04, DWR = 5'h02, DRD = 5'h01;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ctl_wr = 1'b0, csr_wr = 1'b0, csr_rd = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
  logic ctl_irq_enable = 1'b0, ctl_port_enable = 1'b0, ctl_master_select = 1'b0;
  logic ctl_clock_idle_level = 1'b0, ctl_capture_edge_select = 1'b0;
  logic csr_soft_select_mode = 1'b0, csr_soft_select_level = 1'b1;
  logic [7:0] data_wdata = 8'h00;
  logic [7:0] data_rdata;
  logic [7:0] rx;
  logic transfer_done_flag, write_collision_flag, overrun_flag, mode_fault_flag, port_enable, master_select;
  logic cpu_irq_mask = 1'b0, wait_mode = 1'b0, halt_mode = 1'b0, ss_pin_b = 1'b1, pol = 1'b0, pha = 1'b0;
  logic irq_req, wake_req, sck_link, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, mosi_f, miso_f;
  logic mosi_in, miso_in;
  int err_count = 0, n_tests = 0;
  always #50 clk_sys = ~clk_sys;
  // shared data pins resolved from the enables
  assign mosi_in = mosi_oe ? mosi_out : mosi_f;
  assign miso_in = miso_oe ? miso_out : miso_f;
  spc_port #(.MST_HALF_DIV(5)) dut (.clk_sys, .rst_b, .sck_link, .ctl_wr, .ctl_irq_enable, .ctl_port_enable,
    .ctl_master_select, .ctl_clock_idle_level, .ctl_capture_edge_select, .csr_wr, .csr_rd, .csr_soft_select_mode,
    .csr_soft_select_level, .data_wr, .data_rd, .data_wdata, .data_rdata, .transfer_done_flag,
    .write_collision_flag, .overrun_flag, .mode_fault_flag, .port_enable, .master_select, .cpu_irq_mask,
    .wait_mode, .halt_mode, .irq_req, .wake_req, .ss_pin_b, .sck_out, .sck_oe, .mosi_in, .mosi_out, .mosi_oe,
    .miso_in, .miso_out, .miso_oe);
  spc_far_end far (.clk_pol(pol), .clk_pha(pha), .sck_m(sck_out), .mosi_m(mosi_in), .miso_s(miso_in),
    .sck_link(sck_link), .mosi_f(mosi_f), .miso_f(miso_f));
  // ----
  // tasks
  // ----
  // one-cycle strobe; d carries the byte and the control or select bits
  task cpu(input logic [4:0] s, input logic [7:0] d);
    @(negedge clk_sys);
    {ctl_wr, csr_wr, csr_rd, data_wr, data_rd} = s;
    data_wdata = d;
    {ctl_irq_enable, ctl_port_enable, ctl_master_select, ctl_clock_idle_level, ctl_capture_edge_select} = d[4:0];
    {csr_soft_select_mode, csr_soft_select_level} = d[1:0];
    @(negedge clk_sys);
    {ctl_wr, csr_wr, csr_rd, data_wr, data_rd} = 5'h00;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // bounded wait, the flag lags the link by a few synchroniser stages
  task wait_done;
    for (int k = 0; k < 400 && transfer_done_flag !== 1'b1; k++)
      @(negedge clk_sys);
    chk("done", 8'h01, transfer_done_flag);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog, far above the expected run length
  initial
  begin
    #2000000;
    err_count++;
    final_report;
  end
  // ----
  // tests
  // ----
  initial
  begin
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("reset", 8'h00, {transfer_done_flag, write_collision_flag, overrun_flag, mode_fault_flag, port_enable});
    $display("test reset done");
    for (int m = 0; m < 4; m++)
    begin
      pol = m[1];
      pha = m[0];
      cpu(CTL, {6'h00, pol, pha});
      cpu(CSW, 8'h03);
      cpu(CTL, {3'b111, pol, pha});
      far.load(8'h3C + 8'(m));
      cpu(DWR, 8'hA5 ^ 8'(m));
      if (m == 0) cpu(DWR, 8'hFF);
      wait_done;
      chk("rx byte", 8'h3C + 8'(m), data_rdata);
      chk("far byte", 8'hA5 ^ 8'(m), far.rx);
      chk("sck idle", {7'h00, pol}, sck_out);
      chk("irq", 8'h01, irq_req);
      if (m == 0) chk("write_collision_flag", 8'h01, write_collision_flag);
      if (m == 1) cpu(DWR, 8'h11);
      repeat (20) @(negedge clk_sys);
      chk("edges", 8'h10, 8'(far.cnt));
      cpu(CSR, 8'h00);
      cpu(DRD, 8'h00);
      chk("done clr", 8'h00, {write_collision_flag, transfer_done_flag});
    end
    $display("test master modes done");
    cpu(CSW, 8'h00);
    ss_pin_b = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk("fault", 8'h04, {mode_fault_flag, port_enable, master_select});
    chk("fault irq", 8'h01, irq_req);
    chk("fault oe", 8'h00, {sck_oe, mosi_oe});
    cpu_irq_mask = 1'b1;
    @(negedge clk_sys);
    chk("masked", 8'h00, irq_req);
    cpu_irq_mask = 1'b0;
    ss_pin_b = 1'b1;
    pol = 1'b0;
    pha = 1'b0;
    cpu(CTL, 8'h1C);
    chk("fault hold", 8'h04, {mode_fault_flag, port_enable, master_select});
    cpu(CSR, 8'h00);
    cpu(CTL, 8'h1C);
    chk("fault clr", 8'h03, {mode_fault_flag, port_enable, master_select});
    $display("test mode fault done");
    pha = 1'b1;
    cpu(CTL, 8'h19);
    ss_pin_b = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("slave fault", 8'h00, mode_fault_flag);
    chk("slave oe", 8'h01, miso_oe);
    far.send(8'h5A, rx);
    wait_done;
    chk("slave rx", 8'h5A, data_rdata);
    far.send(8'h96, rx);
    chk("echo", 8'h5A, rx);
    repeat (8) @(negedge clk_sys);
    chk("overrun", 8'h01, overrun_flag);
    chk("kept", 8'h5A, data_rdata);
    cpu(CSR, 8'h00);
    chk("ovr clr", 8'h00, overrun_flag);
    cpu(DRD, 8'h00);
    halt_mode = 1'b1;
    far.send(8'h77, rx);
    wait_done;
    chk("halt wake", 8'h01, wake_req);
    halt_mode = 1'b0;
    wait_mode = 1'b1;
    @(negedge clk_sys);
    chk("wait wake", 8'h01, wake_req);
    chk("halt rx", 8'h77, data_rdata);
    wait_mode = 1'b0;
    cpu(CSR, 8'h00);
    cpu(DRD, 8'h00);
    far.send(8'hC3, rx);
    chk("extra echo", 8'h77, rx);
    wait_done;
    cpu(CSR, 8'h00);
    cpu(DRD, 8'h00);
    // phase changes only while disabled, so no false launch edge
    pha = 1'b0;
    cpu(CTL, 8'h11);
    cpu(CTL, 8'h10);
    cpu(CTL, 8'h18);
    cpu(DWR, 8'h00);
    chk("slave write_collision_flag", 8'h01, write_collision_flag);
    chk("write_collision_flag irq", 8'h00, irq_req);
    far.send(8'h81, rx);
    chk("pha0 echo", 8'hC3, rx);
    wait_done;
    chk("pha0 rx", 8'h81, data_rdata);
    $display("test slave and low power done");
    final_report;
  end
endmodule
